// >>> logic/lbtc_consts.svh
// register indices, field positions, reset values and interval codes
`ifndef LBTC_CONSTS_SVH
`define LBTC_CONSTS_SVH
`define LBTC_IDX_CTRL      10'h06B
`define LBTC_IDX_SOFT_TRIG 10'h06C
`define LBTC_IDX_STATUS    10'h06D
`define LBTC_IDX_LP_CFG    10'h06E
`define LBTC_IDX_DATA_EN   10'h070
`define LBTC_IDX_CAL_DATA  10'h071
`define LBTC_RST_CTRL      8'h00
`define LBTC_RST_SOFT_TRIG 8'h01
`define LBTC_RST_LP_CFG    8'h88
`define LBTC_RST_DATA_EN   8'h00
`define LBTC_CTRL_TSEL     0
`define LBTC_CTRL_BGEN     1
`define LBTC_LOWPOWER_BGCAL_ENABLE         0
`define LBTC_LP_WAKE       1
`define LBTC_LP_SET_LSB    3
`define LBTC_LP_SLP_LSB    5
`define LBTC_K_CODE0       6'h03
`define LBTC_SLEEP_KBASE   6'h0C
`define LBTC_SETTLE_KBASE  6'h0F
`define LBTC_K_STEP        6'h03
`define LBTC_K_LIMIT       33
`define LBTC_UNIT_CYCLES   256
`define LBTC_CAL_WORDS     673
`define LBTC_CNT_W         42
`endif

// >>> logic/lbtc_pkg.sv
// types shared by the trigger and low-power calibration control
package lbtc_pkg;
    typedef enum logic [1:0] {
        LBTC_IDLE,
        LBTC_SLEEP,
        LBTC_SETTLE,
        LBTC_CAL
    } lbtc_state_t;

    typedef struct packed {
        logic [2:0] sleepIntervalCode;
        logic [1:0] settleIntervalCode;
        logic       wakeOnTriggerMode;
        logic       lowpowerBgcalEnable;
    } lbtc_lpcfg_t;

    typedef struct packed {
        logic       coreSleep;
        logic       calStart;
        logic [3:0] coreSel;
    } lbtc_core_ctl_t;
endpackage

// >>> logic/lbtc_top.sv
// calibration trigger select, low-power sleep/settle sequencer, APB regs
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "lbtc_consts.svh"

// Behaviour
// [RL1] A software trigger bit at bit 0 stands in for the pin, reset 1.
// [RL2] With the source select at 0 the software bit is the trigger.
// [RL3] Software wanting no trigger keeps select 0 and software bit 1.
// [RL4] Low-power calibration is off at 0 and acts only with bg cal on.
// [RL5] With wake mode 0 the cores sleep for the coded sleep interval.
// [RL6] With wake mode 1 a core sleeps until the chosen trigger is low.
// [RL7] The sleep code is used only when low-power is on and wake mode 0.
// [RL8] Sleep lasts (2^k+1)*256 clocks, k=3 for code 0, else 12+3*code.
// [RL9] Software should not use sleep codes below 4.
// [RL10] After each wake the block waits a settle interval before cal.
// [RL11] Settle lasts (2^k+1)*256 clocks, k=3,18,21,24, reset code 01.
// [RL12] Software should not use settle code 0.
// [RL13] The vector access enable is bit 0 of its own register, reset 0.
// [RL14] With select 1 the pin is the trigger and the soft bit ignored.
// [RL15] The background calibration enable is off at 0 and on at 1.
// [RL16] With access enabled the data register reads and writes the vector.
// [RL17] One device-clock counter times both intervals, restarting per step.
module lbtc_top #(
    parameter int UNIT_CYCLES = `LBTC_UNIT_CYCLES,
    parameter int K_MAX       = `LBTC_K_LIMIT,
    parameter int NUM_CORES   = 2,
    parameter int CAL_WORDS   = `LBTC_CAL_WORDS,
    parameter int ADDR_W      = 12
) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire logic                    ce,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // trigger and calibration engine
    input  wire logic                    hwTrigPin,
    input  wire logic                    calDone,
    output logic                         calTrigger,
    output logic                         bgCalEnable,
    output logic                         calDataEn,
    output lbtc_pkg::lbtc_core_ctl_t     coreCtl
);
    import lbtc_pkg::*;

    localparam int CNT_W = `LBTC_CNT_W;
    localparam int PTR_W = $clog2(CAL_WORDS);

    if (K_MAX < 3 || K_MAX > `LBTC_K_LIMIT) begin : g_bad_k
        $error("K_MAX out of range");
    end
    if (NUM_CORES < 1 || NUM_CORES > 16) begin : g_bad_cores
        $error("NUM_CORES must be 1 to 16");
    end
    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 256 || CAL_WORDS < 2) begin : g_bad
        $error("UNIT_CYCLES or CAL_WORDS out of range");
    end
    if (ADDR_W < 12) begin : g_bad_addr
        $error("ADDR_W too narrow for the map");
    end

    function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                    input logic [9:0] idx);
        regHit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [CNT_W-1:0] intervalLen(input logic [5:0] k);
        logic [5:0] kc;
        kc = (k > 6'(K_MAX)) ? 6'(K_MAX) : k;
        intervalLen = ((CNT_W'(1) << kc) + CNT_W'(1)) * CNT_W'(UNIT_CYCLES);
    endfunction

    // ---- register file ----
    logic        softTrig_reg, softTrig_next;
    logic        trigSel_reg, trigSel_next;
    logic        bgEn_reg, bgEn_next;
    lbtc_lpcfg_t lpCfg_reg, lpCfg_next;
    logic        dataEn_reg, dataEn_next;
    logic [PTR_W-1:0] ptr_reg, ptr_next;
    logic        ready_reg, ready_next;
    logic        slverr_reg, slverr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0]  calMem [CAL_WORDS];
    lbtc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [3:0]  core_reg, core_next;
    logic        start_reg, start_next;

    logic access, done, wrDone, rdDone, mapped, memWr;
    logic [7:0] statusByte, lpByte;

    assign access = psel && penable && ce;
    assign done   = access && ready_reg;
    assign wrDone = done && pwrite;
    assign rdDone = done && !pwrite;
    assign mapped = regHit(paddr, `LBTC_IDX_CTRL)
                 || regHit(paddr, `LBTC_IDX_SOFT_TRIG)
                 || regHit(paddr, `LBTC_IDX_STATUS)
                 || regHit(paddr, `LBTC_IDX_LP_CFG)
                 || regHit(paddr, `LBTC_IDX_DATA_EN)
                 || regHit(paddr, `LBTC_IDX_CAL_DATA);
    assign memWr  = wrDone && dataEn_reg
                 && regHit(paddr, `LBTC_IDX_CAL_DATA); // RL16
    assign lpByte = {lpCfg_reg.sleepIntervalCode,
                     lpCfg_reg.settleIntervalCode, 1'b0,
                     lpCfg_reg.wakeOnTriggerMode,
                     lpCfg_reg.lowpowerBgcalEnable};
    assign statusByte = {core_reg, calTrigger,
                         state_reg == LBTC_CAL,
                         state_reg == LBTC_SETTLE,
                         state_reg == LBTC_SLEEP};

    always_comb begin
        softTrig_next = softTrig_reg;
        trigSel_next  = trigSel_reg;
        bgEn_next     = bgEn_reg;
        lpCfg_next    = lpCfg_reg;
        dataEn_next   = dataEn_reg;
        ptr_next      = ptr_reg;
        rdata_next    = rdata_reg;
        slverr_next   = 1'b0;
        // one wait state so read data comes from a flop
        ready_next    = access && !ready_reg;
        if (access && !ready_reg) begin
            slverr_next = !mapped;
            rdata_next  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (1'b1)
                    regHit(paddr, `LBTC_IDX_CTRL):
                        rdata_next[1:0] = {bgEn_reg, trigSel_reg};
                    regHit(paddr, `LBTC_IDX_SOFT_TRIG):
                        rdata_next[0] = softTrig_reg;
                    regHit(paddr, `LBTC_IDX_STATUS):
                        rdata_next[7:0] = statusByte;
                    regHit(paddr, `LBTC_IDX_LP_CFG):
                        rdata_next[7:0] = lpByte;
                    regHit(paddr, `LBTC_IDX_DATA_EN):
                        rdata_next[0] = dataEn_reg; // RL13
                    regHit(paddr, `LBTC_IDX_CAL_DATA):
                        if (dataEn_reg) begin
                            rdata_next[7:0] = calMem[ptr_reg]; // RL16
                        end
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
        if (wrDone) begin
            if (regHit(paddr, `LBTC_IDX_CTRL)) begin
                trigSel_next = pwdata[`LBTC_CTRL_TSEL];
                bgEn_next    = pwdata[`LBTC_CTRL_BGEN]; // RL15
            end
            if (regHit(paddr, `LBTC_IDX_SOFT_TRIG)) begin
                softTrig_next = pwdata[0]; // RL1
            end
            if (regHit(paddr, `LBTC_IDX_LP_CFG)) begin
                lpCfg_next.sleepIntervalCode =
                    pwdata[`LBTC_LP_SLP_LSB +: 3];
                lpCfg_next.settleIntervalCode =
                    pwdata[`LBTC_LP_SET_LSB +: 2];
                lpCfg_next.wakeOnTriggerMode = pwdata[`LBTC_LP_WAKE];
                lpCfg_next.lowpowerBgcalEnable = pwdata[`LBTC_LOWPOWER_BGCAL_ENABLE];
            end
            if (regHit(paddr, `LBTC_IDX_DATA_EN)) begin
                dataEn_next = pwdata[0]; // RL13
            end
        end
        // each completed vector access steps the stream pointer
        if ((wrDone || rdDone) && dataEn_reg
                && regHit(paddr, `LBTC_IDX_CAL_DATA)) begin
            ptr_next = (ptr_reg == PTR_W'(CAL_WORDS - 1)) ?
                       '0 : ptr_reg + PTR_W'(1); // RL16
        end
        if (!dataEn_next) begin
            ptr_next = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            softTrig_reg <= 1'(`LBTC_RST_SOFT_TRIG); // RL1
            trigSel_reg  <= 1'(`LBTC_RST_CTRL);
            bgEn_reg     <= 1'b0;
            lpCfg_reg    <= lbtc_lpcfg_t'(7'(`LBTC_RST_LP_CFG >> 1) & 7'h7C
                            | 7'(`LBTC_RST_LP_CFG & 8'h03)); // RL4 RL11
            dataEn_reg   <= 1'(`LBTC_RST_DATA_EN); // RL13
            ptr_reg      <= '0;
            ready_reg    <= 1'b0;
            slverr_reg   <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
        end else if (ce) begin
            softTrig_reg <= softTrig_next;
            trigSel_reg  <= trigSel_next;
            bgEn_reg     <= bgEn_next;
            lpCfg_reg    <= lpCfg_next;
            dataEn_reg   <= dataEn_next;
            ptr_reg      <= ptr_next;
            ready_reg    <= ready_next;
            slverr_reg   <= slverr_next;
            rdata_reg    <= rdata_next;
        end
    end

    // vector storage has no reset; contents are undefined until written
    always_ff @(posedge ref_clk) begin
        if (ce && memWr) begin
            calMem[ptr_reg] <= pwdata[7:0];
        end
    end

    assign pready  = ready_reg && ce;
    assign pslverr = slverr_reg;
    assign prdata  = rdata_reg;

    // ---- trigger and sequencer ----
    logic lpActive, wakeMode;
    logic [5:0] sleepK, settleK;
    logic [CNT_W-1:0] sleepLen, settleLen;

    assign calTrigger = trigSel_reg ? hwTrigPin : softTrig_reg; // RL2 RL14
    assign lpActive = lpCfg_reg.lowpowerBgcalEnable && bgEn_reg; // RL4
    assign wakeMode = lpCfg_reg.wakeOnTriggerMode;
    assign sleepK = (lpCfg_reg.sleepIntervalCode == 3'h0) ? `LBTC_K_CODE0 :
                    `LBTC_SLEEP_KBASE + `LBTC_K_STEP *
                    {3'h0, lpCfg_reg.sleepIntervalCode}; // RL8
    assign settleK = (lpCfg_reg.settleIntervalCode == 2'h0) ? `LBTC_K_CODE0 :
                     `LBTC_SETTLE_KBASE + `LBTC_K_STEP *
                     {4'h0, lpCfg_reg.settleIntervalCode}; // RL11
    assign sleepLen  = intervalLen(sleepK);
    assign settleLen = intervalLen(settleK);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + CNT_W'(1); // RL17
        core_next  = core_reg;
        start_next = 1'b0;
        unique case (state_reg)
            LBTC_IDLE: begin
                cnt_next = '0;
                if (lpActive) begin
                    state_next = LBTC_SLEEP;
                end
            end
            LBTC_SLEEP: begin
                // sleep code only counts in autonomous mode
                if (wakeMode ? !calTrigger : // RL6
                        (cnt_reg >= sleepLen - CNT_W'(1))) begin // RL5 RL7
                    state_next = LBTC_SETTLE;
                    cnt_next   = '0; // RL17
                end
            end
            LBTC_SETTLE: begin
                if (cnt_reg >= settleLen - CNT_W'(1)) begin // RL10
                    state_next = LBTC_CAL;
                    start_next = 1'b1;
                    cnt_next   = '0;
                end
            end
            LBTC_CAL: begin
                cnt_next = '0;
                if (calDone) begin
                    state_next = LBTC_SLEEP;
                    core_next  = (core_reg == 4'(NUM_CORES - 1)) ?
                                 4'h0 : core_reg + 4'h1;
                end
            end
        endcase
        if (!lpActive) begin
            state_next = LBTC_IDLE; // RL4
            cnt_next   = '0;
            start_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= LBTC_IDLE;
            cnt_reg   <= '0;
            core_reg  <= 4'h0;
            start_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            core_reg  <= core_next;
            start_reg <= start_next;
        end
    end

    assign coreCtl = '{coreSleep: (state_reg == LBTC_SLEEP),
                       calStart:  start_reg,
                       coreSel:   core_reg};
    assign bgCalEnable       = bgEn_reg;
    assign calDataEn         = dataEn_reg;

    // ---- checks ----
    sequence sSettleDone;
        state_reg == LBTC_SETTLE && cnt_reg == settleLen - CNT_W'(1)
            && lpActive && ce;
    endsequence
    sequence sCalBegins;
        state_reg == LBTC_CAL && start_reg;
    endsequence

    a_soft_trig_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !trigSel_reg |-> calTrigger == softTrig_reg) // RL2
        else $error("soft trigger not selected");
    a_hw_trig_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
        trigSel_reg |-> calTrigger == hwTrigPin) // RL14
        else $error("pin trigger not selected");
    a_lp_gating: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ce && !(lpCfg_reg.lowpowerBgcalEnable && bgEn_reg)
        |=> state_reg == LBTC_IDLE) // RL4
        else $error("sequencer ran while disabled");
    a_wake_on_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ce && lpActive && state_reg == LBTC_SLEEP && wakeMode && !calTrigger
        |=> state_reg == LBTC_SETTLE && cnt_reg == '0) // RL6
        else $error("core did not wake on low trigger");
    a_trig_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ce && lpActive && state_reg == LBTC_SLEEP && wakeMode && calTrigger
        |=> state_reg == LBTC_SLEEP) // RL7
        else $error("woke without trigger");
    a_sleep_length: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg == LBTC_SETTLE && $past(state_reg) == LBTC_SLEEP
        && !$past(wakeMode) |-> $past(cnt_reg) == $past(sleepLen) - 1) // RL8
        else $error("sleep interval wrong length");
    a_settle_then_cal: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        sSettleDone |=> sCalBegins) // RL10
        else $error("calibration did not follow settle");
    a_settle_length: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sCalBegins |-> $past(cnt_reg) == $past(settleLen) - 1) // RL11
        else $error("settle interval wrong length");
    a_cnt_restart: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_reg != $past(state_reg) |-> cnt_reg == '0) // RL17
        else $error("interval counter not restarted");
    a_vec_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ce && !dataEn_reg |=> ptr_reg == '0) // RL16
        else $error("vector pointer moved while disabled");
endmodule

// >>> tb/testbench.sv
// self-checking bench for the trigger select and low-power cal sequencer
`timescale 1ns/100ps
`include "lbtc_consts.svh"
module testbench;
    import lbtc_pkg::*;
    // short intervals: code 0 gives 9 cycles, the others 17
    localparam int UNIT = 1;
    localparam int KMAX = 4;
    logic           ref_clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           ce = 1'b1;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0;
    logic           pready;
    logic [31:0]    prdata;
    logic           pslverr;
    logic           hwTrigPin = 1'b1;
    logic           calDone = 1'b0;
    logic           calTrigger;
    logic           bgCalEnable;
    logic           calDataEn;
    lbtc_core_ctl_t coreCtl;
    int             failures = 0;
    int             samplesChecked = 0;
    int             cycles = 0;
    int             seed = 32'h492a;
    logic [31:0]    rdData;
    logic           rdErr;
    logic [31:0]    vec [3];
    logic [9:0]     idxTab [4] = '{`LBTC_IDX_CTRL, `LBTC_IDX_SOFT_TRIG,
                                   `LBTC_IDX_LP_CFG, `LBTC_IDX_DATA_EN};
    logic [7:0]     mskTab [4] = '{8'h03, 8'h01, 8'hFB, 8'h01};

    lbtc_top #(.UNIT_CYCLES(UNIT), .K_MAX(KMAX)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .hwTrigPin(hwTrigPin), .calDone(calDone),
        .calTrigger(calTrigger), .bgCalEnable(bgCalEnable),
        .calDataEn(calDataEn), .coreCtl(coreCtl)
    );

    always #2 ref_clk = ~ref_clk;

    // hang guard, far beyond the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    task finish_test;
        if (failures == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task chkb(input string name, input logic exp, input logic got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    task tick;
        @(posedge ref_clk);
        #1;
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'h2, n);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input string name, input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(name, {24'h0, exp}, rdData);
        chkb("read error", 1'b0, rdErr);
    endtask

    function automatic int ilen(input int k);
        return ((1 << ((k > KMAX) ? KMAX : k)) + 1) * UNIT;
    endfunction

    function automatic int sleepLen(input int c);
        return ilen((c == 0) ? 3 : 12 + 3 * c);
    endfunction

    function automatic int settleLen(input int c);
        return ilen((c == 0) ? 3 : 15 + 3 * c);
    endfunction

    // one autonomous sleep, settle, calibrate round on one core
    task run_seq(input logic [7:0] cfg);
        int n;
        int s0;
        apb(1'b1, `LBTC_IDX_CTRL, 32'h0);
        apb(1'b1, `LBTC_IDX_LP_CFG, {24'h0, cfg});
        repeat (4) tick();
        chkb("sleep without bg", 1'b0, coreCtl.coreSleep);
        apb(1'b1, `LBTC_IDX_CTRL, 32'h2);
        n = 0;
        while (coreCtl.coreSleep !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chkb("bg enable", 1'b1, bgCalEnable);
        n = 0;
        while (coreCtl.coreSleep === 1'b1 && n < 200) begin
            tick();
            n++;
        end
        chk("sleep length", sleepLen(cfg[7:5]), n);
        n = 0;
        while (coreCtl.calStart !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        chk("settle length", settleLen(cfg[4:3]), n);
        s0 = coreCtl.coreSel;
        tick();
        chkb("cal start pulse", 1'b0, coreCtl.calStart);
        @(posedge ref_clk);
        calDone <= 1'b1;
        @(posedge ref_clk);
        calDone <= 1'b0;
        n = 0;
        while (coreCtl.coreSleep !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chk("next core", (s0 + 1) % 2, {28'h0, coreCtl.coreSel});
    endtask

    initial begin : main
        int n;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick();
        chkb("reset trigger", 1'b1, calTrigger);
        rdchk("ctrl reset", `LBTC_IDX_CTRL, `LBTC_RST_CTRL);
        rdchk("soft trig reset", `LBTC_IDX_SOFT_TRIG, 8'h01);
        rdchk("lp cfg reset", `LBTC_IDX_LP_CFG, 8'h88);
        rdchk("data en reset", `LBTC_IDX_DATA_EN, 8'h00);
        // unmapped place: error answer, write dropped, read zero
        apb(1'b1, 10'h000, 32'hFF);
        chkb("unmapped error", 1'b1, rdErr);
        apb(1'b0, 10'h000, 32'h0);
        chk("unmapped read", 32'h0, rdData);
        for (int i = 0; i < 12; i++) begin
            n = $unsigned($random(seed)) % 4;
            vec[0] = $random(seed);
            apb(1'b1, idxTab[n], vec[0]);
            rdchk("reg readback", idxTab[n], vec[0][7:0] & mskTab[n]);
        end
        apb(1'b1, `LBTC_IDX_LP_CFG, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `LBTC_IDX_SOFT_TRIG, i % 2);
            apb(1'b1, `LBTC_IDX_CTRL, (i / 2) % 2);
            @(posedge ref_clk);
            hwTrigPin <= 1'($random(seed));
            tick();
            chkb("trigger select", (i / 2) % 2 ? hwTrigPin : 1'(i % 2),
                 calTrigger);
        end
        @(posedge ref_clk);
        hwTrigPin <= 1'b1;
        run_seq(8'h89);
        run_seq(8'h01);
        run_seq(8'hF9);
        // wake-on-trigger: sleep code 0 must not end the sleep
        apb(1'b1, `LBTC_IDX_CTRL, 32'h0);
        apb(1'b1, `LBTC_IDX_SOFT_TRIG, 32'h1);
        apb(1'b1, `LBTC_IDX_LP_CFG, 32'h03);
        apb(1'b1, `LBTC_IDX_CTRL, 32'h3);
        repeat (30) tick();
        chkb("wake mode holds sleep", 1'b1, coreCtl.coreSleep);
        @(posedge ref_clk);
        hwTrigPin <= 1'b0;
        n = 0;
        while (coreCtl.coreSleep === 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chkb("wake on low trigger", 1'b1, n <= 2);
        @(posedge ref_clk);
        hwTrigPin <= 1'b1;
        apb(1'b1, `LBTC_IDX_CTRL, 32'h0);
        tick();
        chkb("bg off stops sleep", 1'b0, coreCtl.coreSleep);
        rdchk("bg off idles", `LBTC_IDX_STATUS, 8'h18);
        // clock enable low must freeze the sleep count
        apb(1'b1, `LBTC_IDX_LP_CFG, 32'h89);
        apb(1'b1, `LBTC_IDX_CTRL, 32'h2);
        @(posedge ref_clk);
        ce <= 1'b0;
        repeat (40) tick();
        chkb("ce freezes sleep", 1'b1, coreCtl.coreSleep);
        @(posedge ref_clk);
        ce <= 1'b1;
        apb(1'b1, `LBTC_IDX_CTRL, 32'h0);
        // vector access: dropped while off, pointer restarts on enable
        apb(1'b1, `LBTC_IDX_DATA_EN, 32'h0);
        rdchk("vector read while off", `LBTC_IDX_CAL_DATA, 8'h00);
        chkb("vector enable off", 1'b0, calDataEn);
        apb(1'b1, `LBTC_IDX_DATA_EN, 32'h1);
        for (int i = 0; i < 3; i++) begin
            vec[i] = $random(seed);
            apb(1'b1, `LBTC_IDX_CAL_DATA, vec[i]);
        end
        chkb("vector enable on", 1'b1, calDataEn);
        apb(1'b1, `LBTC_IDX_DATA_EN, 32'h0);
        apb(1'b1, `LBTC_IDX_DATA_EN, 32'h1);
        for (int i = 0; i < 3; i++)
            rdchk("vector data", `LBTC_IDX_CAL_DATA, vec[i][7:0]);
        apb(1'b1, `LBTC_IDX_DATA_EN, 32'h0);
        finish_test();
    end
endmodule
